//--- rtl/ssa_pkg.sv
// package: register map, field positions, reset values and carriers for the sum/alert block
package ssa_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] SSA_ADDR_SUM = 8'h0d;
    localparam logic [7:0] SSA_ADDR_THRESH = 8'h0e;
    localparam logic [7:0] SSA_ADDR_MASK = 8'h0f;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SSA_RST_SUM = 16'h0000;
    localparam logic [15:0] SSA_RST_THRESH = 16'h7ffe;
    localparam logic [15:0] SSA_RST_MASK = 16'h0002;

    // ------------------------------------------------------------
    // field positions in the mask/flags register
    // ------------------------------------------------------------
    localparam int SSA_NCH = 3;
    localparam int SSA_B_SEL_HI = 14;
    localparam int SSA_B_SEL_LO = 12;
    localparam int SSA_B_WLATCH = 11;
    localparam int SSA_B_CLATCH = 10;
    localparam int SSA_B_CF_HI = 9;
    localparam int SSA_B_CF_LO = 7;
    localparam int SSA_B_SF = 6;
    localparam int SSA_B_WF_HI = 5;
    localparam int SSA_B_WF_LO = 3;
    localparam int SSA_B_PG = 2;
    localparam int SSA_B_TC = 1;
    localparam int SSA_B_CD = 0;

    // one lsb of the sum and threshold fields, in microvolts
    localparam int SSA_LSB_UV = 40;

    // configuration mode codes that do not clear conversion-done
    localparam logic [2:0] SSA_MODE_PWRDN_A = 3'h0;
    localparam logic [2:0] SSA_MODE_PWRDN_B = 3'h4;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [15:0] wdata;
    } ssa_req_t;

    // per-conversion measurement events from the converter
    typedef struct packed {
        logic shunt_valid;
        logic [1:0] shunt_ch;
        logic [15:0] shunt_data;
        logic [2:0] crit_over;
        logic [2:0] warn_over;
        logic cycle_done;
    } ssa_meas_t;

endpackage

//--- rtl/ssa_hold_mem.sv
// small register bank holding the newest shunt sample of each channel
module ssa_hold_mem #(
    parameter int DEPTH = 3,
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // write side
    input wire logic we,
    input wire logic [1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // all entries, registered
    output logic [DEPTH*WIDTH-1:0] rdata
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // every entry is exposed because the sum needs all of them at once
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge clk) begin
                if (srst) begin
                    rdata[gi*WIDTH +: WIDTH] <= '0;
                end else if (we && (waddr == 2'(gi))) begin
                    rdata[gi*WIDTH +: WIDTH] <= wdata;
                end
            end
        end
    endgenerate

endmodule

//--- rtl/ssa_top.sv
// shunt sum, sum limit compare and alert flag logic of a three-channel monitor
// How it works
// - sum adds held shunt samples of channels whose select bits 14..12 are set
// - sum register loads only when a full conversion cycle finishes
// - sum reads as two's complement in bits 15..1, bit 0 zero
// - sum and threshold share a 40 microvolt step per lsb
// - sum compared with threshold each cycle; threshold at 0x0e, resets 0x7ffe
// - sum above threshold sets summation flag bit 6 and critical alert
// - select bits only steer the sum, never channel enables or measurements
// - bit 11 picks warning alert mode: 0 transparent, 1 latched
// - bit 10 picks critical alert mode: 0 transparent, 1 latched
// - critical over-limit sets flag bits 9..7 and asserts critical alert
// - warning over-limit sets flag bits 5..3 and asserts warning alert
// - reading mask register clears critical, sum and warning flags; writes keep flags
// - bit 2 mirrors power-good output, independent of reads
// - bit 1 mirrors timing output, high at reset, cleared when its level drops, set again only by reset
// - conversion-done bit 0 sets when the cycle completes
// - conversion-done clears on mask read or active-mode config write
// - result registers readable any time with latest data, no stall
// - mask at 0x0f resets 0x0002; sum at 0x0d resets zero; bit 15 reserved
// - critical checks each conversion, warning checks averaged value
module ssa_top
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port from the serial front end
    input wire ssa_pkg::ssa_req_t req,
    output logic [15:0] rdata,
    output logic rvalid,
    // converter events, same clock
    input wire ssa_pkg::ssa_meas_t meas,
    // configuration register write seen by the front end
    input wire logic cfg_wr,
    input wire logic [2:0] cfg_mode,
    // power-good and timing comparators, same clock
    input wire logic pg_level,
    input wire logic tc_level,
    // alert outputs, high when asserted
    output logic crit_alert,
    output logic warn_alert,
    output logic power_good_output,
    output logic timing_ctl_output
);
    import ssa_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] sum_q, sum_d;
    logic [15:0] thr_q, thr_d;
    logic [2:0] sum_channel_select;
    logic crit_latch_on, warn_latch_on;
    logic [2:0] sel_q, sel_d;
    logic cl_q, cl_d, wl_q, wl_d;
    logic [2:0] crit_channel_flags, cf_d;
    logic [2:0] warn_channel_flags, wf_d;
    logic sum_over_flag, sf_d;
    logic conv_done_flag, cd_d;
    logic tc_q, tc_d;
    logic pg_q;
    logic calert_q, calert_d, walert_q, walert_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q;
    logic [3*16-1:0] held;

    assign sum_channel_select = sel_q;
    assign crit_latch_on = cl_q;
    assign warn_latch_on = wl_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire hit_sum = (req.addr == SSA_ADDR_SUM);
    wire hit_thr = (req.addr == SSA_ADDR_THRESH);
    wire hit_mask = (req.addr == SSA_ADDR_MASK);
    wire rd_mask = req.rd && hit_mask;
    wire wr_mask = req.wr && hit_mask;
    wire wr_thr = req.wr && hit_thr;

    // ------------------------------------------------------------
    // held samples and sum
    // ------------------------------------------------------------
    // every single conversion is stored; channel enables are untouched
    ssa_hold_mem #(.DEPTH(SSA_NCH), .WIDTH(16)) u_hold (
        .clk(clk),
        .srst(srst),
        .we(meas.shunt_valid),
        .waddr(meas.shunt_ch),
        .wdata(meas.shunt_data),
        .rdata(held)
    );

    // the newest sample enters in the same cycle it arrives, so a done
    // pulse coinciding with the last conversion still sums it
    logic [2:0][16:0] term;
    genvar gc;
    generate
        for (gc = 0; gc < SSA_NCH; gc++) begin : g_term
            wire [15:0] smp = (meas.shunt_valid && meas.shunt_ch == 2'(gc)) ?
                meas.shunt_data : held[gc*16 +: 16];
            // bit 14..12 map to channel 1..3: channel 1 is the highest bit
            assign term[gc] = sum_channel_select[SSA_NCH-1-gc] ? {smp[15], smp} :
                17'h00000;
        end
    endgenerate
    // two guard bits keep three full-scale terms from wrapping before saturation
    wire [17:0] raw_sum = {term[0][16], term[0]} + {term[1][16], term[1]} +
        {term[2][16], term[2]};

    // saturate to the 16-bit two's complement range, lsb is 40 uV
    wire sat_hi = !raw_sum[17] && (raw_sum[16:15] != 2'b00);
    wire sat_lo = raw_sum[17] && (raw_sum[16:15] != 2'b11);
    wire [15:0] sum_sat = sat_hi ? 16'h7ffe : (sat_lo ? 16'h8000 : raw_sum[15:0]);
    wire [15:0] sum_new = {sum_sat[15:1], 1'b0};

    // ------------------------------------------------------------
    // compare
    // ------------------------------------------------------------
    wire sum_over = $signed(sum_new) > $signed(thr_q);
    wire sum_evt = meas.cycle_done && sum_over;

    // channel 1 lands in the highest flag bit, the same order as the select field
    wire [2:0] crit_in = {meas.crit_over[0], meas.crit_over[1], meas.crit_over[2]};
    wire [2:0] warn_in = {meas.warn_over[0], meas.warn_over[1], meas.warn_over[2]};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        sum_d = meas.cycle_done ? sum_new : sum_q;
        thr_d = wr_thr ? {req.wdata[15:1], 1'b0} : thr_q;
        sel_d = wr_mask ? req.wdata[SSA_B_SEL_HI:SSA_B_SEL_LO] : sel_q;
        wl_d = wr_mask ? req.wdata[SSA_B_WLATCH] : wl_q;
        cl_d = wr_mask ? req.wdata[SSA_B_CLATCH] : cl_q;
        // a mask read clears, but a same-cycle event wins; writes never touch flags
        cf_d = (rd_mask ? 3'h0 : crit_channel_flags) | crit_in;
        wf_d = (rd_mask ? 3'h0 : warn_channel_flags) | warn_in;
        sf_d = (rd_mask ? 1'b0 : sum_over_flag) | sum_evt;
        cd_d = conv_done_flag;
        if (rd_mask || (cfg_wr && cfg_mode != SSA_MODE_PWRDN_A &&
                cfg_mode != SSA_MODE_PWRDN_B)) begin
            cd_d = 1'b0;
        end
        if (meas.cycle_done) begin
            cd_d = 1'b1;
        end
        tc_d = tc_q & tc_level;
    end

    // alert pins: transparent follows the comparisons, latch holds until a mask read
    wire crit_now = (|meas.crit_over) || sum_evt;
    wire warn_now = |meas.warn_over;
    always_comb begin
        calert_d = crit_latch_on ? ((calert_q && !rd_mask) || crit_now) : crit_now;
        walert_d = warn_latch_on ? ((walert_q && !rd_mask) || warn_now) : warn_now;
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // reads never stall: the answer is always one cycle later
    wire [15:0] mask_view = {1'b0, sel_q, wl_q, cl_q, crit_channel_flags, sum_over_flag,
        warn_channel_flags, pg_q, tc_q, conv_done_flag};
    assign rdata_d = hit_sum ? sum_q : (hit_thr ? thr_q : (hit_mask ? mask_view : 16'h0000));

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            sum_q <= SSA_RST_SUM;
            thr_q <= SSA_RST_THRESH;
            sel_q <= SSA_RST_MASK[SSA_B_SEL_HI:SSA_B_SEL_LO];
            wl_q <= SSA_RST_MASK[SSA_B_WLATCH];
            cl_q <= SSA_RST_MASK[SSA_B_CLATCH];
            crit_channel_flags <= 3'h0;
            warn_channel_flags <= 3'h0;
            sum_over_flag <= 1'b0;
            conv_done_flag <= SSA_RST_MASK[SSA_B_CD];
            tc_q <= SSA_RST_MASK[SSA_B_TC];
            pg_q <= SSA_RST_MASK[SSA_B_PG];
            calert_q <= 1'b0;
            walert_q <= 1'b0;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            sum_q <= sum_d;
            thr_q <= thr_d;
            sel_q <= sel_d;
            wl_q <= wl_d;
            cl_q <= cl_d;
            crit_channel_flags <= cf_d;
            warn_channel_flags <= wf_d;
            sum_over_flag <= sf_d;
            conv_done_flag <= cd_d;
            tc_q <= tc_d;
            pg_q <= pg_level;
            calert_q <= calert_d;
            walert_q <= walert_d;
            rdata_q <= req.rd ? rdata_d : rdata_q;
            rvalid_q <= req.rd;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign crit_alert = calert_q;
    assign warn_alert = walert_q;
    assign power_good_output = pg_q;
    assign timing_ctl_output = tc_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_done_over;
        meas.cycle_done && sum_over;
    endsequence

    sum_load_a: assert property (meas.cycle_done |=> sum_q == $past(sum_new))
        else $error("sum not loaded at cycle end");
    sum_hold_a: assert property (!meas.cycle_done |=> $stable(sum_q))
        else $error("sum changed between cycles");
    sum_lsb_a: assert property (sum_q[0] == 1'b0)
        else $error("sum bit 0 not zero");
    sum_flag_a: assert property (s_done_over |=> sum_over_flag && crit_alert)
        else $error("sum over limit missed");
    crit_flag_a: assert property (|meas.crit_over |=> (crit_channel_flags &
        $past(crit_in)) == $past(crit_in) && crit_alert)
        else $error("critical flag missed");
    warn_flag_a: assert property (|meas.warn_over |=> warn_alert)
        else $error("warning alert missed");
    read_clear_a: assert property (rd_mask && !(|meas.crit_over) && !(|meas.warn_over)
        && !meas.cycle_done |=> crit_channel_flags == 3'h0 && warn_channel_flags == 3'h0
        && !sum_over_flag && !conv_done_flag)
        else $error("mask read did not clear flags");
    write_keep_a: assert property (wr_mask && !rd_mask && !(|meas.crit_over)
        |=> crit_channel_flags == $past(crit_channel_flags))
        else $error("mask write changed flags");
    tc_sticky_a: assert property (!tc_q |=> !tc_q)
        else $error("timing flag rose without reset");
    done_set_a: assert property (meas.cycle_done |=> conv_done_flag)
        else $error("conversion done not set");
    latch_hold_a: assert property (cl_q && crit_alert && !rd_mask && !wr_mask
        |=> crit_alert)
        else $error("latched critical alert dropped");
    transp_a: assert property (!wl_q && !wr_mask |=> warn_alert == $past(warn_now))
        else $error("transparent warning not following");

    // register port: every read is answered the next cycle, never stalled
    read_ans_a: assert property (req.rd |=> rvalid && rdata == $past(rdata_d))
        else $error("read not answered next cycle");
    unmapped_a: assert property (req.rd && !hit_sum && !hit_thr && !hit_mask
        |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    mask_rsvd_a: assert property (rd_mask |=> rdata[15] == 1'b0)
        else $error("reserved mask bit read high");
    thr_write_a: assert property (wr_thr |=> thr_q == ($past(req.wdata) & 16'hfffe))
        else $error("threshold write lost");
    thr_lsb_a: assert property (thr_q[0] == 1'b0)
        else $error("threshold bit 0 not zero");

    // with no channel selected there is nothing to add
    sequence s_done_none;
        meas.cycle_done && sum_channel_select == 3'h0;
    endsequence
    sum_none_a: assert property (s_done_none |=> sum_q == 16'h0000)
        else $error("sum not zero with no channel selected");

    // warning flags are kept per channel like the critical ones
    warn_bits_a: assert property (|meas.warn_over |=> (warn_channel_flags &
        $past(warn_in)) == $past(warn_in))
        else $error("warning flag missed");
    write_warn_a: assert property (wr_mask && !rd_mask && !(|meas.warn_over)
        |=> warn_channel_flags == $past(warn_channel_flags))
        else $error("mask write changed warning flags");

    // an active-mode configuration write drops conversion-done unless a cycle ends
    sequence s_active_cfg;
        cfg_wr && cfg_mode != SSA_MODE_PWRDN_A && cfg_mode != SSA_MODE_PWRDN_B;
    endsequence
    done_clear_a: assert property (s_active_cfg ##0 !meas.cycle_done
        |=> !conv_done_flag)
        else $error("conversion done kept after config write");

    // power-good pin follows its level one cycle later; timing pin drops one cycle after its level
    pg_mirror_a: assert property (1'b1 |=> power_good_output == $past(pg_level))
        else $error("power-good pin not following its level");
    tc_drop_a: assert property (!tc_level |=> !timing_ctl_output)
        else $error("timing pin did not drop");

    // the other alert in each mode behaves like its partner above
    warn_hold_a: assert property (wl_q && warn_alert && !rd_mask && !wr_mask
        |=> warn_alert)
        else $error("latched warning alert dropped");
    crit_transp_a: assert property (!cl_q && !wr_mask
        |=> crit_alert == $past(crit_now))
        else $error("transparent critical not following");

endmodule

//--- test/ssa_host_model.sv
// host-side model issuing register reads and writes on the block's request port
module ssa_host_model
(
    // clock
    input wire logic clk,
    // request and answer
    output ssa_pkg::ssa_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    import ssa_pkg::*;

    // idle host: no strobe at time zero
    initial begin
        req = '0;
    end

    // ------------------------------------------------------------
    // one-cycle write, taken at the next rising edge
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        @(negedge clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(negedge clk);
        req <= '0;
    endtask

    // ------------------------------------------------------------
    // one-cycle read; a missing rvalid turns the result unknown
    // ------------------------------------------------------------
    task automatic rd(input logic [7:0] addr, output logic [15:0] data);
        @(negedge clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 16'h0000};
        @(negedge clk);
        data = (rvalid === 1'b1) ? rdata : 16'hxxxx;
        req <= '0;
    endtask
endmodule

//--- test/testbench.sv
// self-checking bench for the shunt sum and alert flag block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ssa_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic srst = 1'b1;
    ssa_req_t req;
    ssa_meas_t meas = '0;
    logic [15:0] rdata;
    logic rvalid;
    logic cfg_wr = 1'b0;
    logic [2:0] cfg_mode = 3'h0;
    logic pg_level = 1'b0;
    logic tc_level = 1'b1;
    logic crit_alert;
    logic warn_alert;
    logic power_good_output;
    logic timing_ctl_output;
    logic [15:0] v;
    int bad_count = 0;
    int tests_run = 0;

    always #5 clk = ~clk;

    ssa_top ssa_top_i (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid),
        .meas(meas), .cfg_wr(cfg_wr), .cfg_mode(cfg_mode), .pg_level(pg_level),
        .tc_level(tc_level), .crit_alert(crit_alert), .warn_alert(warn_alert),
        .power_good_output(power_good_output), .timing_ctl_output(timing_ctl_output));

    ssa_host_model ssa_host_model_i (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] addr, input logic [15:0] exp);
        ssa_host_model_i.rd(addr, v);
        chk(v, exp);
    endtask

    // one converter event: sample, over-limit bits and cycle end in the same cycle
    task automatic conv(input logic [1:0] ch, input logic [15:0] d, input logic done,
                        input logic [2:0] co, input logic [2:0] wo);
        @(negedge clk);
        meas <= '{shunt_valid: 1'b1, shunt_ch: ch, shunt_data: d, crit_over: co,
                  warn_over: wo, cycle_done: done};
        @(negedge clk);
        meas <= '0;
    endtask

    task automatic cfg(input logic [2:0] mode);
        @(negedge clk);
        cfg_wr <= 1'b1;
        cfg_mode <= mode;
        @(negedge clk);
        cfg_wr <= 1'b0;
    endtask

    // verdict and end of run, shared with the watchdog
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // a hung handshake must not stall the run; the tests need well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        srst <= 1'b0;
        rchk(SSA_ADDR_SUM, 16'h0000);
        rchk(SSA_ADDR_THRESH, 16'h7ffe);
        rchk(SSA_ADDR_MASK, 16'h0002);
        rchk(8'h10, 16'h0000);
        $display("test reset values done");
        // threshold bit 0 is reserved and the sum is read-only
        ssa_host_model_i.wr(SSA_ADDR_THRESH, 16'h0081);
        rchk(SSA_ADDR_THRESH, 16'h0080);
        ssa_host_model_i.wr(SSA_ADDR_SUM, 16'h1234);
        rchk(SSA_ADDR_SUM, 16'h0000);
        $display("test register access done");
        // channels 1 and 3 selected; reserved bit 15 written high reads low
        ssa_host_model_i.wr(SSA_ADDR_MASK, 16'hd000);
        rchk(SSA_ADDR_MASK, 16'h5002);
        conv(2'd0, 16'h0100, 1'b0, 3'h0, 3'h0);
        conv(2'd1, 16'h0200, 1'b0, 3'h0, 3'h0);
        rchk(SSA_ADDR_SUM, 16'h0000);
        conv(2'd2, 16'hffc0, 1'b1, 3'h0, 3'h0);
        chk({15'h0, crit_alert}, 16'h0001);
        rchk(SSA_ADDR_SUM, 16'h00c0);
        rchk(SSA_ADDR_MASK, 16'h5043);
        rchk(SSA_ADDR_MASK, 16'h5002);
        ssa_host_model_i.wr(SSA_ADDR_THRESH, 16'h7ffe);
        conv(2'd1, 16'h7000, 1'b1, 3'h0, 3'h0);
        rchk(SSA_ADDR_SUM, 16'h00c0);
        chk({15'h0, crit_alert}, 16'h0000);
        // three 0x7000 samples saturate high, three 0x8000 low; no channel selected sums zero
        ssa_host_model_i.wr(SSA_ADDR_MASK, 16'h7000);
        conv(2'd0, 16'h7000, 1'b0, 3'h0, 3'h0);
        conv(2'd1, 16'h7000, 1'b0, 3'h0, 3'h0);
        conv(2'd2, 16'h7000, 1'b1, 3'h0, 3'h0);
        rchk(SSA_ADDR_SUM, 16'h7ffe);
        conv(2'd0, 16'h8000, 1'b0, 3'h0, 3'h0);
        conv(2'd1, 16'h8000, 1'b0, 3'h0, 3'h0);
        conv(2'd2, 16'h8000, 1'b1, 3'h0, 3'h0);
        rchk(SSA_ADDR_SUM, 16'h8000);
        ssa_host_model_i.wr(SSA_ADDR_MASK, 16'h0000);
        conv(2'd0, 16'h0100, 1'b1, 3'h0, 3'h0);
        rchk(SSA_ADDR_SUM, 16'h0000);
        ssa_host_model_i.wr(SSA_ADDR_MASK, 16'hd000);
        $display("test summation done");
        // transparent alerts follow single-cycle events
        conv(2'd0, 16'h0000, 1'b0, 3'h2, 3'h0);
        chk({15'h0, crit_alert}, 16'h0001);
        @(negedge clk);
        chk({15'h0, crit_alert}, 16'h0000);
        conv(2'd0, 16'h0000, 1'b0, 3'h0, 3'h4);
        chk({15'h0, warn_alert}, 16'h0001);
        @(negedge clk);
        chk({15'h0, warn_alert}, 16'h0000);
        rchk(SSA_ADDR_MASK, 16'h510b);
        $display("test transparent alerts done");
        // flags were read and cleared above before the latch settings change
        ssa_host_model_i.wr(SSA_ADDR_MASK, 16'h5c00);
        conv(2'd0, 16'h0000, 1'b0, 3'h1, 3'h1);
        repeat (5) @(negedge clk);
        chk({14'h0, crit_alert, warn_alert}, 16'h0003);
        ssa_host_model_i.wr(SSA_ADDR_MASK, 16'h5c00);
        rchk(SSA_ADDR_MASK, 16'h5e22);
        @(negedge clk);
        chk({14'h0, crit_alert, warn_alert}, 16'h0000);
        $display("test latched alerts done");
        // power-down modes keep the conversion-done bit, active modes clear it
        conv(2'd0, 16'h0000, 1'b1, 3'h0, 3'h0);
        cfg(SSA_MODE_PWRDN_B);
        rchk(SSA_ADDR_MASK, 16'h5c03);
        conv(2'd0, 16'h0000, 1'b1, 3'h0, 3'h0);
        cfg(3'h7);
        rchk(SSA_ADDR_MASK, 16'h5c02);
        $display("test conversion done flag done");
        // power-good mirrors its level through reads; timing flag is sticky
        pg_level <= 1'b1;
        repeat (2) @(negedge clk);
        chk({15'h0, power_good_output}, 16'h0001);
        rchk(SSA_ADDR_MASK, 16'h5c06);
        rchk(SSA_ADDR_MASK, 16'h5c06);
        pg_level <= 1'b0;
        tc_level <= 1'b0;
        repeat (2) @(negedge clk);
        tc_level <= 1'b1;
        repeat (2) @(negedge clk);
        chk({15'h0, timing_ctl_output}, 16'h0000);
        rchk(SSA_ADDR_MASK, 16'h5c00);
        srst <= 1'b1;
        repeat (2) @(negedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk({15'h0, timing_ctl_output}, 16'h0001);
        rchk(SSA_ADDR_MASK, 16'h0002);
        $display("test power-good and timing flags done");
        complete_run();
    end
endmodule
